/* pfmc_pkg.sv */
// Package for the power-fault and master-clear control block.
// Assumes a 100 MHz core clock and an APB slave with 32-bit data.
package pfmc_pkg;
  // ************************************************************
  // Timing.
  // ************************************************************
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned PF_HOLD_US = 250;
  localparam int unsigned PF_HOLD_CYC = PF_HOLD_US * CLK_MHZ;
  localparam int unsigned IC_MIN_MS = 256;
  localparam int unsigned IC_MAX_MS = 512;
  localparam int unsigned IC_INT_CYC = IC_MIN_MS * 1000 * CLK_MHZ;
  localparam int unsigned IC_BIT8_TOGGLES = 2;
  localparam int unsigned RTC_TICK_BIT = 8;
  // ************************************************************
  // Register offsets, byte addresses.
  // ************************************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_IDX = 8'h08;
  localparam logic [7:0] REG_SERIAL = 8'h0c;
  // CTRL bits.
  localparam int unsigned CTRL_LPSW = 0;
  localparam int unsigned CTRL_BOOT = 1;
  localparam int unsigned CTRL_ICLOAD = 2;
  localparam int unsigned CTRL_ICACK = 3;
  localparam int unsigned CTRL_EXT = 4;
  localparam int unsigned CTRL_MCLR = 5;
  // STAT bits.
  localparam int unsigned ST_PFREQ = 0;
  localparam int unsigned ST_PFLOCK = 1;
  localparam int unsigned ST_PFIND = 2;
  localparam int unsigned ST_PGIND = 3;
  localparam int unsigned ST_ICTO = 4;
  localparam int unsigned ST_ICBUSY = 5;
  localparam int unsigned ST_VOUT = 6;
  localparam int unsigned ST_JUMPHOLD = 7;
  // Index layout and interrupt codes.
  localparam int unsigned IDX_SH_12 = 1;
  localparam int unsigned IDX_SH_3 = 4;
  localparam logic [2:0] PF_CODE = 3'h0;
  localparam logic [1:0] ICTO_CODE = 2'h3;
  localparam logic [15:0] BOOT_ADDR = 16'h0000;
  localparam logic [1:0] SER188_CTL_SET = 2'h3;
  localparam int unsigned NUM_PAGES = 64;
  typedef enum logic [1:0] {
    PF_IDLE = 2'b00,
    PF_HOLD = 2'b01,
    PF_CLEAR = 2'b10
  } pfmc_pf_state_t;
endpackage

/* pfmc_index.sv */
// Interrupt entrance index and address formation.
// Assumes the base word is supplied by the caller from assigned memory.
`timescale 1ns/100ps
module pfmc_index
  import pfmc_pkg::*;
(
  input wire logic i_class3,
  input wire logic [2:0] i_code,
  input wire logic [15:0] i_base,
  output logic [15:0] o_index,
  output logic [15:0] o_entry
);
  // Code field sits at its class-dependent offset, upper bits zero.
  always_comb begin
    if (i_class3) begin
      o_index = {10'h000, i_code[1:0], 4'h0};
    end else begin
      o_index = {12'h000, i_code, 1'b0};
    end
    o_entry = i_base + o_index;
  end
endmodule

/* pfmc_timeout.sv */
// Intercomputer acknowledge time-out for one channel group.
// Assumes the real-time counter bit 8 is supplied synchronously.
`timescale 1ns/100ps
module pfmc_timeout
  import pfmc_pkg::*;
#(
  parameter int unsigned TO_CYC = IC_INT_CYC
) (
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic i_load,
  input wire logic i_ack,
  input wire logic i_ext,
  input wire logic i_rtc_bit8,
  input wire logic i_clr,
  output logic o_busy,
  output logic o_expire
);
  logic busy;
  logic next_busy;
  logic [31:0] cnt;
  logic [31:0] next_cnt;
  logic [1:0] tog;
  logic [1:0] next_tog;
  logic bit8_d;
  logic next_bit8_d;
  logic fire;
  // Internal timing counts cycles; external timing counts bit 8 edges.
  always_comb begin
    next_busy = busy;
    next_cnt = cnt;
    next_tog = tog;
    next_bit8_d = i_rtc_bit8;
    fire = 1'b0;
    if (i_clr) begin
      next_busy = 1'b0;
    end else if (i_load) begin
      next_busy = 1'b1;
      next_cnt = 32'h0;
      next_tog = 2'h0;
    end else if (busy && i_ack) begin
      next_busy = 1'b0;
    end else if (busy) begin
      if (i_ext) begin
        if (i_rtc_bit8 != bit8_d) begin
          next_tog = tog + 2'h1;
        end
        fire = (tog == 2'(IC_BIT8_TOGGLES));
      end else begin
        next_cnt = cnt + 32'h1;
        fire = (cnt == TO_CYC - 1);
      end
      if (fire) begin
        next_busy = 1'b0;
      end
    end
  end
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      busy <= 1'b0;
      cnt <= 32'h0;
      tog <= 2'h0;
      bit8_d <= 1'b0;
    end else begin
      busy <= next_busy;
      cnt <= next_cnt;
      tog <= next_tog;
      bit8_d <= next_bit8_d;
    end
  end
  assign o_busy = busy;
  assign o_expire = fire;
endmodule

/* pfmc_ctrl.sv */
// Power fault, time-out, auto start and master clear control, APB slave.
// Assumes synchronous panel and supply inputs and a 100 MHz core clock.
//
// The placing of the registers and the APB slave port are this design's own decisions.
`timescale 1ns/100ps
module pfmc_ctrl
  import pfmc_pkg::*;
#(
  parameter int unsigned PF_CYC = PF_HOLD_CYC,
  parameter int unsigned IC_CYC = IC_INT_CYC
) (
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic i_volt_bad,
  input wire logic i_auto_start,
  input wire logic i_supply_fault_clear_switch,
  input wire logic i_prog_fault_clear_switch,
  input wire logic i_illegal_instr,
  input wire logic i_rtc_bit8,
  input wire logic [15:0] i_int_base,
  input wire logic i_int_class3,
  input wire logic [2:0] i_int_code,
  output logic [15:0] o_int_entry,
  output logic o_pf_int_req,
  output logic o_icto_int_req,
  output logic o_master_clear,
  output logic o_start,
  output logic [15:0] o_start_addr,
  output logic o_jump_taken,
  output logic o_clear_p_status,
  output logic o_counters_halt,
  output logic o_page_load,
  output logic o_channel_clear_instr,
  output logic o_pf_lamp,
  output logic o_prog_fault_lamp,
  output logic o_normal_display_select,
  output logic [1:0] o_mil188_ctl_56,
  output logic o_discretes_clear,
  output logic o_tx_idle
);
  // ************************************************************
  // State.
  // ************************************************************
  pfmc_pf_state_t st;
  pfmc_pf_state_t next_st;
  logic pf_lock;
  logic next_pf_lock;
  logic pf_req;
  logic next_pf_req;
  logic pf_lamp;
  logic next_pf_lamp;
  logic pg_lamp;
  logic next_pg_lamp;
  logic icto;
  logic next_icto;
  logic ext_timing;
  logic next_ext_timing;
  logic counters_halt;
  logic next_counters_halt;
  logic norm_dsp;
  logic next_norm_dsp;
  logic mclr;
  logic next_mclr;
  logic pf_seen;
  logic next_pf_seen;
  logic start;
  logic next_start;
  logic powered;
  logic next_powered;
  logic [31:0] hold_cnt;
  logic [31:0] next_hold_cnt;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic wr_acc;
  logic rd_acc;
  logic sw_lpsw;
  logic sw_boot;
  logic sw_load;
  logic sw_ack;
  logic sw_mclr;
  logic sw_icto_clr;
  logic to_busy;
  logic to_expire;
  logic [15:0] idx;
  logic [31:0] stat_word;
  // ************************************************************
  // APB slave.
  // ************************************************************
  // Zero-wait slave; unmapped addresses answer with pslverr.
  assign pready = 1'b1;
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && !penable && !pwrite;
  assign pslverr = psel && penable && !(paddr == REG_CTRL || paddr == REG_STAT ||
    paddr == REG_IDX || paddr == REG_SERIAL);
  assign sw_lpsw = wr_acc && paddr == REG_CTRL && pwdata[CTRL_LPSW];
  assign sw_boot = wr_acc && paddr == REG_CTRL && pwdata[CTRL_BOOT];
  assign sw_load = wr_acc && paddr == REG_CTRL && pwdata[CTRL_ICLOAD];
  assign sw_ack = wr_acc && paddr == REG_CTRL && pwdata[CTRL_ICACK];
  assign sw_mclr = wr_acc && paddr == REG_CTRL && pwdata[CTRL_MCLR];
  assign sw_icto_clr = wr_acc && paddr == REG_STAT && pwdata[ST_ICTO];
  always_comb begin
    stat_word = 32'h0;
    stat_word[ST_PFREQ] = pf_req;
    stat_word[ST_PFLOCK] = pf_lock;
    stat_word[ST_PFIND] = pf_lamp;
    stat_word[ST_PGIND] = pg_lamp;
    stat_word[ST_ICTO] = icto;
    stat_word[ST_ICBUSY] = to_busy;
    stat_word[ST_VOUT] = i_volt_bad;
    stat_word[ST_JUMPHOLD] = i_volt_bad;
  end
  // Read data is captured in the setup cycle so it comes from a flop.
  always_comb begin
    next_rdata = rdata;
    if (rd_acc) begin
      case (paddr)
        REG_CTRL: next_rdata = {31'h0, ext_timing} << CTRL_EXT;
        REG_STAT: next_rdata = stat_word;
        REG_IDX: next_rdata = {16'h0, idx};
        REG_SERIAL: next_rdata = {29'h0, o_tx_idle, o_mil188_ctl_56};
        default: next_rdata = 32'h0;
      endcase
    end
  end
  assign prdata = rdata;
  // ************************************************************
  // Power fault sequencing and master clear.
  // ************************************************************
  // The hold count keeps the clear off long enough for the save routine.
  always_comb begin
    next_st = st;
    next_pf_lock = pf_lock;
    next_pf_req = 1'b0;
    next_pf_lamp = pf_lamp;
    next_pg_lamp = pg_lamp;
    next_hold_cnt = hold_cnt;
    next_mclr = 1'b0;
    next_pf_seen = pf_seen;
    next_start = 1'b0;
    next_powered = 1'b1;
    next_counters_halt = counters_halt;
    next_norm_dsp = norm_dsp;
    next_ext_timing = ext_timing;
    if (wr_acc && paddr == REG_CTRL) begin
      next_ext_timing = pwdata[CTRL_EXT];
    end
    if (sw_lpsw) begin
      next_pf_lock = 1'b0;
      next_counters_halt = 1'b0;
    end
    if (sw_boot) begin
      next_pf_lock = 1'b1;
    end
    if (!powered && i_auto_start) begin
      next_start = 1'b1;
    end
    if (i_supply_fault_clear_switch) begin
      next_pf_lamp = 1'b0;
    end
    if (i_prog_fault_clear_switch) begin
      next_pg_lamp = 1'b0;
    end
    if (i_illegal_instr) begin
      next_pg_lamp = 1'b1;
    end
    case (st)
      PF_IDLE: begin
        if (i_volt_bad && !pf_lock) begin
          next_pf_req = 1'b1;
          next_pf_lock = 1'b1;
          next_pf_lamp = 1'b1;
          next_pf_seen = 1'b1;
          next_hold_cnt = 32'h0;
          next_st = PF_HOLD;
        end else if (sw_mclr) begin
          next_st = PF_CLEAR;
        end
      end
      PF_HOLD: begin
        next_hold_cnt = hold_cnt + 32'h1;
        if (hold_cnt >= PF_CYC - 1) begin
          if (i_volt_bad) begin
            next_st = PF_CLEAR;
          end else begin
            next_st = PF_IDLE;
          end
        end
      end
      PF_CLEAR: begin
        next_mclr = 1'b1;
        next_pf_lamp = 1'b0;
        next_pg_lamp = 1'b0;
        next_norm_dsp = 1'b1;
        next_counters_halt = 1'b1;
        if (!i_volt_bad) begin
          next_st = PF_IDLE;
          next_start = pf_seen && i_auto_start;
          next_pf_seen = 1'b0;
        end
      end
      default: next_st = PF_IDLE;
    endcase
  end
  // ************************************************************
  // Link time-out pending flag.
  // ************************************************************
  // One pending flag for the group; a new expiry beats a clear.
  always_comb begin
    next_icto = icto;
    if (sw_icto_clr || mclr) begin
      next_icto = 1'b0;
    end
    if (to_expire) begin
      next_icto = 1'b1;
    end
  end
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st <= PF_IDLE;
      pf_lock <= 1'b1;
      pf_req <= 1'b0;
      pf_lamp <= 1'b0;
      pg_lamp <= 1'b0;
      hold_cnt <= 32'h0;
      mclr <= 1'b0;
      pf_seen <= 1'b0;
      start <= 1'b0;
      powered <= 1'b0;
      counters_halt <= 1'b1;
      norm_dsp <= 1'b1;
      ext_timing <= 1'b0;
      icto <= 1'b0;
      rdata <= 32'h0;
    end else begin
      st <= next_st;
      pf_lock <= next_pf_lock;
      pf_req <= next_pf_req;
      pf_lamp <= next_pf_lamp;
      pg_lamp <= next_pg_lamp;
      hold_cnt <= next_hold_cnt;
      mclr <= next_mclr;
      pf_seen <= next_pf_seen;
      start <= next_start;
      powered <= next_powered;
      counters_halt <= next_counters_halt;
      norm_dsp <= next_norm_dsp;
      ext_timing <= next_ext_timing;
      icto <= next_icto;
      rdata <= next_rdata;
    end
  end
  // ************************************************************
  // Submodules and outputs.
  // ************************************************************
  pfmc_timeout #(.TO_CYC(IC_CYC)) u_to (
    .i_core_clk(i_core_clk),
    .i_nrst(i_nrst),
    .i_load(sw_load),
    .i_ack(sw_ack),
    .i_ext(ext_timing),
    .i_rtc_bit8(i_rtc_bit8),
    .i_clr(mclr),
    .o_busy(to_busy),
    .o_expire(to_expire)
  );
  pfmc_index u_idx (
    .i_class3(i_int_class3),
    .i_code(i_int_code),
    .i_base(i_int_base),
    .o_index(idx),
    .o_entry(o_int_entry)
  );
  assign o_pf_int_req = pf_req;
  assign o_icto_int_req = icto;
  assign o_master_clear = mclr;
  assign o_clear_p_status = mclr;
  assign o_page_load = mclr;
  assign o_channel_clear_instr = mclr;
  assign o_discretes_clear = mclr;
  assign o_mil188_ctl_56 = mclr ? SER188_CTL_SET : 2'h0;
  assign o_tx_idle = mclr;
  assign o_counters_halt = counters_halt;
  assign o_pf_lamp = pf_lamp;
  assign o_prog_fault_lamp = pg_lamp;
  assign o_normal_display_select = norm_dsp;
  assign o_start = start;
  assign o_start_addr = BOOT_ADDR;
  assign o_jump_taken = i_volt_bad;
  // ************************************************************
  // Assertions.
  // ************************************************************
  sequence pf_raise_s;
    pf_req ##1 (st == PF_HOLD);
  endsequence
  pf_lock_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    pf_lock && !sw_lpsw |=> !pf_req) else $error("fault raised while locked");
  pf_raise_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (st == PF_IDLE && i_volt_bad && !pf_lock) |=> pf_req && pf_lamp)
    else $error("fault not raised");
  pf_hold_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    pf_raise_s |-> !mclr [*8]) else $error("clear too early");
  icto_set_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    to_expire |=> icto) else $error("timeout lost");
  mclr_lamp_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    mclr |-> !pf_lamp && !pg_lamp && norm_dsp) else $error("lamps lit in clear");
  mclr_ser_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    mclr |-> o_mil188_ctl_56 == 2'h3 && o_tx_idle) else $error("serial not idle");
  idx_zero_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    idx[15:6] == 10'h0) else $error("index upper bits set");
  pg_lamp_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    i_illegal_instr && st != PF_CLEAR |=> pg_lamp) else $error("program fault lamp dark");
  clear_sw_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    $rose(i_supply_fault_clear_switch) && st == PF_IDLE && !i_volt_bad |=> !pf_lamp)
    else $error("clear switch ignored");
endmodule

/* pfmc_far_model.sv */
// Far-side model: supply monitor, panel clear switches and the real-time counter.
// Assumes the block's counter halt output and one 100 MHz core clock.
`timescale 1ns/100ps
module pfmc_far_model (
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic i_counters_halt,
  output logic o_volt_bad,
  output logic o_rtc_bit8,
  output logic o_supply_fault_clear_switch,
  output logic o_prog_fault_clear_switch
);
  logic [15:0] rtc;

  // ************************************************************
  // Real-time counter.
  // ************************************************************
  // It stands still while the block halts the counters, as a real one would.
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) rtc <= 16'h0000;
    else if (!i_counters_halt) rtc <= rtc + 16'h0001;
  end
  assign o_rtc_bit8 = rtc[8];

  // Supply and switches rest in their quiet state.
  initial begin
    o_volt_bad = 1'b0;
    o_supply_fault_clear_switch = 1'b0;
    o_prog_fault_clear_switch = 1'b0;
  end

  // Supply out of tolerance for n cycles, then back in tolerance.
  task automatic sag(input int n);
    @(posedge i_core_clk);
    o_volt_bad <= 1'b1;
    repeat (n) @(posedge i_core_clk);
    o_volt_bad <= 1'b0;
  endtask

  // Momentary operation of one clear switch; a real toggle bounces back.
  task automatic press(input bit prog);
    @(posedge i_core_clk);
    if (prog) o_prog_fault_clear_switch <= 1'b1;
    else o_supply_fault_clear_switch <= 1'b1;
    repeat (4) @(posedge i_core_clk);
    o_prog_fault_clear_switch <= 1'b0;
    o_supply_fault_clear_switch <= 1'b0;
  endtask
endmodule

/* pfmc_tb.sv */
// Self-checking testbench for the power-fault and master-clear control block.
// Assumes pfmc_ctrl with shortened counts and the far-side model beside it.
`timescale 1ns/100ps
module testbench
  import pfmc_pkg::*;
;
  localparam int PF = 20;
  localparam int IC = 50;
  logic i_core_clk, i_nrst, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, seed;
  logic auto_start, illegal, class3, volt_bad, rtc_bit8, pf_sw, pg_sw, last8;
  logic [15:0] base, entry, start_addr;
  logic [2:0] code;
  logic pf_req, icto, mclr, start, jump, clr_st, halt, page_ld, ch_clr;
  logic pf_lamp, pg_lamp, norm_dsp, disc_clr, tx_idle;
  logic [1:0] ctl56;
  int fail_count, checks_done, pf_seen, start_seen, mc_seen, n, tog;

  pfmc_ctrl #(.PF_CYC(PF), .IC_CYC(IC)) DUT (
    .i_core_clk(i_core_clk), .i_nrst(i_nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .i_volt_bad(volt_bad), .i_auto_start(auto_start),
    .i_supply_fault_clear_switch(pf_sw), .i_prog_fault_clear_switch(pg_sw),
    .i_illegal_instr(illegal), .i_rtc_bit8(rtc_bit8), .i_int_base(base),
    .i_int_class3(class3), .i_int_code(code), .o_int_entry(entry), .o_pf_int_req(pf_req),
    .o_icto_int_req(icto), .o_master_clear(mclr), .o_start(start),
    .o_start_addr(start_addr), .o_jump_taken(jump), .o_clear_p_status(clr_st),
    .o_counters_halt(halt), .o_page_load(page_ld), .o_channel_clear_instr(ch_clr),
    .o_pf_lamp(pf_lamp), .o_prog_fault_lamp(pg_lamp), .o_normal_display_select(norm_dsp),
    .o_mil188_ctl_56(ctl56), .o_discretes_clear(disc_clr), .o_tx_idle(tx_idle)
  );

  pfmc_far_model far (
    .i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_counters_halt(halt),
    .o_volt_bad(volt_bad), .o_rtc_bit8(rtc_bit8),
    .o_supply_fault_clear_switch(pf_sw), .o_prog_fault_clear_switch(pg_sw)
  );

  // ************************************************************
  // Helpers.
  // ************************************************************
  initial begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; the request stands until pready is seen high.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge i_core_clk);
    penable <= 1'b1;
    @(posedge i_core_clk);
    while (pready !== 1'b1) @(posedge i_core_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return s[0] ? ((s >> 1) ^ 32'h80200003) : (s >> 1);
  endfunction

  function automatic logic [15:0] idx_of(input logic c3, input logic [2:0] cd);
    return c3 ? {10'h000, cd[1:0], 4'h0} : {12'h000, cd, 1'b0};
  endfunction

  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Event counters read the values from before each edge, so no race.
  always @(posedge i_core_clk) begin
    if (pf_req === 1'b1) pf_seen++;
    if (start === 1'b1) start_seen++;
    if (mclr === 1'b1) mc_seen++;
  end

  // Steady relations are looked at mid-cycle, where everything has settled.
  always @(negedge i_core_clk) begin
    if (i_nrst === 1'b1) begin
      check(32'(jump), 32'(volt_bad));
      if (mclr === 1'b1) begin
        check(32'({ctl56, disc_clr, tx_idle}), 32'({SER188_CTL_SET, 2'b11}));
        check(32'({clr_st, page_ld, ch_clr}), 32'h7);
      end
    end
  end

  // The whole run needs about a thousand cycles; this cuts a hang short.
  initial begin
    repeat (10000) @(posedge i_core_clk);
    fail_count++;
    conclude();
  end

  // ************************************************************
  // Main sequence.
  // ************************************************************
  initial begin
    {psel, penable, pwrite, illegal, class3} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    base = 16'h0000;
    code = 3'h0;
    auto_start = 1'b1;
    i_nrst = 1'b0;
    seed = 32'h6e978001;
    repeat (16) @(posedge i_core_clk);
    i_nrst <= 1'b1;
    @(posedge i_core_clk);
    #1;
    check(32'(start), 32'h1);
    check(32'({start_addr, halt, norm_dsp}), 32'h3);
    apb(1'b0, REG_STAT, 32'h0);
    check(32'(rd[ST_PFLOCK]), 32'h1);
    far.sag(4);
    repeat (4) @(posedge i_core_clk);
    check(32'(pf_seen), 32'h0);
    $display("test reset and power-up lock done");
    // A marginal sag that recovers before the hold runs out.
    apb(1'b1, REG_CTRL, 32'h1);
    @(posedge i_core_clk);
    #1 check(32'(halt), 32'h0);
    far.sag(5);
    repeat (PF + 10) @(posedge i_core_clk);
    check(32'(pf_seen), 32'h1);
    check(32'(mc_seen), 32'h0);
    check(32'(pf_lamp), 32'h1);
    apb(1'b0, REG_STAT, 32'h0);
    check(32'(rd[ST_PFLOCK]), 32'h1);
    far.sag(4);
    repeat (4) @(posedge i_core_clk);
    check(32'(pf_seen), 32'h1);
    far.press(1'b0);
    repeat (2) @(posedge i_core_clk);
    check(32'(pf_lamp), 32'h0);
    illegal <= 1'b1;
    @(posedge i_core_clk);
    illegal <= 1'b0;
    repeat (2) @(posedge i_core_clk);
    check(32'(pg_lamp), 32'h1);
    far.press(1'b1);
    repeat (2) @(posedge i_core_clk);
    check(32'(pg_lamp), 32'h0);
    $display("test marginal fault and lamps done");
    // A lasting fault: hold, master clear, then restart.
    apb(1'b1, REG_CTRL, 32'h1);
    illegal <= 1'b1;
    @(posedge i_core_clk);
    illegal <= 1'b0;
    fork
      far.sag(PF + 30);
    join_none
    n = 0;
    while (pf_req !== 1'b1 && n < 20) begin @(posedge i_core_clk); #1; n++; end
    n = 0;
    while (mclr !== 1'b1 && n < PF + 20) begin @(posedge i_core_clk); #1; n++; end
    check(32'(n >= PF && n <= PF + 2), 32'h1);
    n = 0;
    while (start !== 1'b1 && n < 100) begin @(posedge i_core_clk); #1; n++; end
    check(32'({start, start_addr}), {15'h0000, 1'b1, BOOT_ADDR});
    check(32'({pf_lamp, pg_lamp, norm_dsp, halt}), 32'h3);
    apb(1'b0, REG_STAT, 32'h0);
    check(rd & 32'h0000000c, 32'h0);
    // Software master clear with the selector off auto gives no restart.
    auto_start <= 1'b0;
    apb(1'b1, REG_CTRL, 32'h20);
    repeat (10) @(posedge i_core_clk);
    check(32'(start_seen), 32'h2);
    check(32'(mc_seen > PF), 32'h1);
    auto_start <= 1'b1;
    $display("test master clear done");
    // Link word acknowledged, then left unanswered on internal timing.
    apb(1'b1, REG_CTRL, 32'h1);
    apb(1'b1, REG_CTRL, 32'h4);
    apb(1'b0, REG_STAT, 32'h0);
    check(32'(rd[ST_ICBUSY]), 32'h1);
    apb(1'b1, REG_CTRL, 32'h8);
    repeat (2 * IC) @(posedge i_core_clk);
    apb(1'b0, REG_STAT, 32'h0);
    check(32'({rd[ST_ICTO], rd[ST_ICBUSY]}), 32'h0);
    apb(1'b1, REG_CTRL, 32'h4);
    n = 0;
    while (icto !== 1'b1 && n < 3 * IC) begin @(posedge i_core_clk); #1; n++; end
    check(32'(n >= IC - 2 && n <= 2 * IC), 32'h1);
    apb(1'b1, REG_STAT, 32'h10);
    @(posedge i_core_clk);
    #1 check(32'(icto), 32'h0);
    // External timing: expiry follows the second toggle of counter bit 8.
    apb(1'b1, REG_CTRL, 32'h14);
    last8 = rtc_bit8;
    tog = 0;
    n = 0;
    while (icto !== 1'b1 && n < 2000) begin
      @(posedge i_core_clk);
      #1;
      n++;
      if (rtc_bit8 !== last8) tog++;
      last8 = rtc_bit8;
    end
    check(32'(tog), 32'h2);
    apb(1'b1, REG_STAT, 32'h10);
    // A bootstrap load locks the fault again after a status-word load.
    apb(1'b1, REG_CTRL, 32'h1);
    apb(1'b1, REG_CTRL, 32'h2);
    apb(1'b0, REG_STAT, 32'h0);
    check(32'(rd[ST_PFLOCK]), 32'h1);
    far.sag(4);
    repeat (4) @(posedge i_core_clk);
    check(32'(pf_seen), 32'h2);
    $display("test link time-out done");
    // Entrance address over random inputs, the two fixed codes first.
    for (int i = 0; i < 24; i++) begin
      seed = lfsr(seed);
      @(posedge i_core_clk);
      base <= seed[15:0];
      {class3, code} <= (i == 0) ? 4'h0 : (i == 1) ? 4'hb : seed[19:16];
      apb(1'b0, REG_IDX, 32'h0);
      check(32'(entry), 32'(16'(base + idx_of(class3, code))));
      check(rd, 32'(idx_of(class3, code)));
    end
    apb(1'b0, 8'h10, 32'h0);
    check({rd[30:0], err}, 32'h1);
    $display("test entrance address and unmapped read done");
    conclude();
  end
endmodule
